/* File: common/cbt_pkg.sv */
// shared constants and types for the central bus module transfer logic
package cbt_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int DATA_W = 16;
    localparam int MODN_W = 3;
    localparam int NUM_MODULES = 8;
    localparam int MOP_W = 2;

    // ----------------------------------------
    // memory opcodes
    // ----------------------------------------
    localparam logic [1:0] MOP_NOP = 2'h0;
    localparam logic [1:0] MOP_WRITE = 2'h1;
    localparam logic [1:0] MOP_READ = 2'h2;
    localparam logic [1:0] MOP_RD_ONES = 2'h3;

    // ----------------------------------------
    // default module numbers and reset values
    // ----------------------------------------
    localparam logic [2:0] CPU_MODN_DEF = 3'h1;
    localparam logic [2:0] MEM_MODN_DEF = 3'h2;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [2:0] MODN_RST = 3'h0;
    localparam logic [7:0] ALL_HIGH8 = 8'hFF;

    // ----------------------------------------
    // processor transfer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        CBT_IDLE,
        CBT_WAIT_RDY,
        CBT_WAIT_PRIO,
        CBT_SEL
    } cbt_cpu_st_t;
endpackage

/* File: common/cbt_bus_if.sv */
// central data bus: data, module numbers, opcode, ready and enable lines
`timescale 1ns/1ns
interface cbt_bus_if;
    // bus word and tags (wired-or of all drivers)
    logic [15:0] data;
    logic [2:0]  to_num;
    logic [2:0]  from_num;
    logic [1:0]  mem_opcode;
    logic        valid;
    // per-module ready lines, high = busy (wired-or)
    logic [7:0]  rdy_n_pull;
    // per-module priority enable lines, low = requesting
    logic [7:0]  pri_n;
    // i/o processor holding the bus
    logic        iop_req;

    // cpu end drives these
    logic [15:0] cpu_data;
    logic [2:0]  cpu_to;
    logic [2:0]  cpu_from;
    logic [1:0]  cpu_mop;
    logic        cpu_drive;
    logic [7:0]  cpu_rdy_pull;
    logic [7:0]  cpu_pri_pull;
    // memory end drives these
    logic [15:0] mem_data;
    logic [2:0]  mem_to;
    logic [2:0]  mem_from;
    logic [1:0]  mem_mop;
    logic        mem_drive;
    logic [7:0]  mem_rdy_pull;
    logic [7:0]  mem_pri_pull;

    assign data = (cpu_drive ? cpu_data : 16'h0000) | (mem_drive ? mem_data : 16'h0000);
    assign to_num = (cpu_drive ? cpu_to : 3'h0) | (mem_drive ? mem_to : 3'h0);
    assign from_num = (cpu_drive ? cpu_from : 3'h0) | (mem_drive ? mem_from : 3'h0);
    assign mem_opcode = (cpu_drive ? cpu_mop : 2'h0) | (mem_drive ? mem_mop : 2'h0);
    assign valid = cpu_drive | mem_drive;
    assign rdy_n_pull = cpu_rdy_pull | mem_rdy_pull;
    assign pri_n = ~(cpu_pri_pull | mem_pri_pull);

    modport cpu_mp (
        input  data, to_num, from_num, mem_opcode, valid, rdy_n_pull, pri_n, iop_req,
        output cpu_data, cpu_to, cpu_from, cpu_mop, cpu_drive, cpu_rdy_pull, cpu_pri_pull
    );
    modport mem_mp (
        input  data, to_num, from_num, mem_opcode, valid, rdy_n_pull, pri_n,
        output mem_data, mem_to, mem_from, mem_mop, mem_drive, mem_rdy_pull, mem_pri_pull
    );
endinterface

/* File: verilog/cbt_mem_end.sv */
// memory module bus interface: address receive, read reply, write data receive
`timescale 1ns/1ns
module cbt_mem_end #(
    parameter logic [2:0] MY_MODN = cbt_pkg::MEM_MODN_DEF,
    parameter bit         ONES_AS_NOP = 1'b1,
    parameter int         DEPTH = 256
) (
    // clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_IN,
    // bus
    cbt_bus_if.mem_mp        bus,
    // user side: storage access
    output logic             MEM_WR_OUT,
    output logic [15:0]      MEM_ADDR_OUT,
    output logic [15:0]      MEM_WDATA_OUT,
    output logic             MEM_BUSY_OUT
);
    logic [15:0] mem_array [DEPTH];
    logic        ready_ff;
    logic        enable_ff;
    logic        dout_ff;
    logic        wr_wait_ff;
    logic [15:0] addr_ff;
    logic [2:0]  from_ff;
    logic [15:0] mdata_ff;
    logic        wr_ff;
    logic        to_hit;
    logic        from_hit;
    logic        higher_busy;
    logic [1:0]  eff_mop;

    assign to_hit = bus.valid && bus.to_num == MY_MODN;
    assign from_hit = bus.from_num == from_ff;
    // opcode 3 folds to no-operation in the later variant
    assign eff_mop = (ONES_AS_NOP && bus.mem_opcode == cbt_pkg::MOP_RD_ONES) ? cbt_pkg::MOP_NOP : bus.mem_opcode;
    // lower line index means higher priority
    assign higher_busy = (MY_MODN == 3'h0) ? 1'b0 : (~bus.pri_n & ~(cbt_pkg::ALL_HIGH8 << MY_MODN)) != 8'h00;

    // ----------------------------------------
    // ready, address and source capture
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            ready_ff <= 1'b0;
            wr_wait_ff <= 1'b0;
            addr_ff <= cbt_pkg::WORD_RST;
            from_ff <= cbt_pkg::MODN_RST;
        end
        else if (!ready_ff && to_hit && eff_mop != cbt_pkg::MOP_NOP)
        begin
            ready_ff <= 1'b1;
            addr_ff <= bus.data;
            from_ff <= bus.from_num;
            wr_wait_ff <= eff_mop == cbt_pkg::MOP_WRITE;
        end
        else if (ready_ff && wr_wait_ff && to_hit && from_hit)
        begin
            ready_ff <= 1'b0;
            wr_wait_ff <= 1'b0;
        end
        else if (dout_ff)
        begin
            ready_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // read reply and write cycle
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            enable_ff <= 1'b0;
            dout_ff <= 1'b0;
            mdata_ff <= cbt_pkg::WORD_RST;
            wr_ff <= 1'b0;
        end
        else
        begin
            wr_ff <= 1'b0;
            if (ready_ff && !wr_wait_ff && !enable_ff && !dout_ff)
            begin
                mdata_ff <= mem_array[addr_ff[$clog2(DEPTH)-1:0]];
                enable_ff <= 1'b1;
            end
            else if (enable_ff && !higher_busy && !dout_ff)
            begin
                dout_ff <= 1'b1;
                enable_ff <= 1'b0;
            end
            else if (dout_ff)
            begin
                dout_ff <= 1'b0;
            end
            if (ready_ff && wr_wait_ff && to_hit && from_hit)
            begin
                mdata_ff <= bus.data;
                wr_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (wr_ff)
        begin
            mem_array[addr_ff[$clog2(DEPTH)-1:0]] <= mdata_ff;
        end
    end

    // ----------------------------------------
    // bus drive
    // ----------------------------------------
    assign bus.mem_drive = dout_ff;
    assign bus.mem_data = mdata_ff;
    assign bus.mem_from = MY_MODN;
    assign bus.mem_to = from_ff;
    assign bus.mem_mop = cbt_pkg::MOP_NOP;
    assign bus.mem_rdy_pull = ready_ff ? (8'h01 << MY_MODN) : 8'h00;
    assign bus.mem_pri_pull = (enable_ff || dout_ff) ? (8'h01 << MY_MODN) : 8'h00;

    assign MEM_WR_OUT = wr_ff;
    assign MEM_ADDR_OUT = addr_ff;
    assign MEM_WDATA_OUT = mdata_ff;
    assign MEM_BUSY_OUT = ready_ff;
endmodule

/* File: verilog/cbt_cpu_end.sv */
// processor module control unit: fetch, operand read and operand write over the bus
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module cbt_cpu_end #(
    parameter logic [2:0] MY_MODN = cbt_pkg::CPU_MODN_DEF,
    parameter bit         ONES_AS_NOP = 1'b1
) (
    // clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_IN,
    // bus
    cbt_bus_if.cpu_mp        bus,
    // microcode orders, one-cycle pulses, taken only while ready
    input  wire logic        NEXT_IN,
    input  wire logic        OPERAND_READ_IN,
    input  wire logic        OPERAND_WRITE_IN,
    input  wire logic        DATA_IN,
    input  wire logic [15:0] P_IN,
    input  wire logic [15:0] UBUS_IN,
    input  wire logic [2:0]  DEST_IN,
    input  wire logic [1:0]  MOP_IN,
    input  wire logic        STALLED_IN,
    output logic             READY_OUT,
    // processor state
    output logic [15:0]      CUR_INSTR_OUT,
    output logic [15:0]      PREFETCH_OUT,
    output logic [15:0]      OPERAND_OUT,
    output logic [15:0]      SBUS_OUT,
    output logic             SBUS_LOAD_OUT,
    output logic             FETCH_PENDING_OUT,
    output logic             OPERAND_PENDING_OUT,
    output logic [7:0]       MODULE_ID_OUT,
    output logic             MODULE_INT_OUT
);
    cbt_pkg::cbt_cpu_st_t st_ff;
    logic [15:0] outgoing_addr_reg_ff;
    logic [15:0] outgoing_data_reg_ff;
    logic [15:0] current_instr_reg_ff;
    logic [15:0] prefetch_instr_reg_ff;
    logic [15:0] operand_reg_ff;
    logic [15:0] sbus_ff;
    logic        sbus_load_ff;
    logic [2:0]  dest_ff;
    logic [1:0]  mem_opcode_ff;
    logic        low_request_ff;
    logic        high_request_ff;
    logic        fetch_pending_ff;
    logic        operand_pending_ff;
    logic [7:0]  module_id_reg_ff;
    logic        mod_int_ff;
    logic        to_me;
    logic        reply_ok;
    logic        dest_ready;
    logic        higher_busy;
    logic        grant;
    logic        start;
    logic        start_low;
    logic [1:0]  req_mop;

    assign start_low = NEXT_IN || OPERAND_READ_IN || OPERAND_WRITE_IN;
    assign start = start_low || DATA_IN;
    assign READY_OUT = st_ff == cbt_pkg::CBT_IDLE;
    assign to_me = bus.valid && bus.to_num == MY_MODN;
    assign reply_ok = to_me && bus.from_num == dest_ff;
    assign dest_ready = !bus.rdy_n_pull[dest_ff];
    assign higher_busy = (MY_MODN == 3'h0) ? 1'b0 : (~bus.pri_n & ~(cbt_pkg::ALL_HIGH8 << MY_MODN)) != 8'h00;
    assign grant = !higher_busy && !bus.iop_req;
    assign req_mop = (ONES_AS_NOP && MOP_IN == cbt_pkg::MOP_RD_ONES) ? cbt_pkg::MOP_NOP : MOP_IN;

    // ----------------------------------------
    // request sequencing
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            st_ff <= cbt_pkg::CBT_IDLE;
            low_request_ff <= 1'b0;
            high_request_ff <= 1'b0;
        end
        else
        begin
            case (st_ff)
                cbt_pkg::CBT_IDLE:
                begin
                    if (start_low)
                    begin
                        low_request_ff <= 1'b1;
                        st_ff <= cbt_pkg::CBT_WAIT_RDY;
                    end
                    else if (DATA_IN)
                    begin
                        high_request_ff <= 1'b1;
                        st_ff <= cbt_pkg::CBT_WAIT_PRIO;
                    end
                end
                cbt_pkg::CBT_WAIT_RDY:
                begin
                    if (dest_ready)
                    begin
                        st_ff <= cbt_pkg::CBT_WAIT_PRIO;
                    end
                end
                cbt_pkg::CBT_WAIT_PRIO:
                begin
                    if (grant && (high_request_ff || dest_ready))
                    begin
                        st_ff <= cbt_pkg::CBT_SEL;
                    end
                end
                cbt_pkg::CBT_SEL:
                begin
                    low_request_ff <= 1'b0;
                    high_request_ff <= 1'b0;
                    st_ff <= cbt_pkg::CBT_IDLE;
                end
                default:
                begin
                    st_ff <= cbt_pkg::CBT_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // outgoing registers, opcode and destination
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            outgoing_addr_reg_ff <= cbt_pkg::WORD_RST;
            outgoing_data_reg_ff <= cbt_pkg::WORD_RST;
            current_instr_reg_ff <= cbt_pkg::WORD_RST;
            dest_ff <= cbt_pkg::MODN_RST;
            mem_opcode_ff <= cbt_pkg::MOP_NOP;
        end
        else if (READY_OUT && start)
        begin
            dest_ff <= DEST_IN;
            if (NEXT_IN)
            begin
                outgoing_addr_reg_ff <= P_IN;
                current_instr_reg_ff <= prefetch_instr_reg_ff;
                mem_opcode_ff <= cbt_pkg::MOP_READ;
            end
            else if (OPERAND_READ_IN)
            begin
                outgoing_addr_reg_ff <= UBUS_IN;
                mem_opcode_ff <= req_mop;
            end
            else if (OPERAND_WRITE_IN)
            begin
                outgoing_addr_reg_ff <= UBUS_IN;
                mem_opcode_ff <= cbt_pkg::MOP_WRITE;
            end
            else
            begin
                outgoing_data_reg_ff <= UBUS_IN;
                mem_opcode_ff <= cbt_pkg::MOP_NOP;
            end
        end
    end

    // ----------------------------------------
    // pending flags and receive
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            fetch_pending_ff <= 1'b0;
            operand_pending_ff <= 1'b0;
            prefetch_instr_reg_ff <= cbt_pkg::WORD_RST;
            operand_reg_ff <= cbt_pkg::WORD_RST;
            sbus_ff <= cbt_pkg::WORD_RST;
            sbus_load_ff <= 1'b0;
        end
        else
        begin
            sbus_load_ff <= 1'b0;
            if (fetch_pending_ff && bus.valid)
            begin
                prefetch_instr_reg_ff <= bus.data;
            end
            if (operand_pending_ff && reply_ok)
            begin
                operand_reg_ff <= bus.data;
                if (STALLED_IN)
                begin
                    sbus_ff <= bus.data;
                    sbus_load_ff <= 1'b1;
                end
            end
            // a new order wins over a reply in the same cycle
            if (READY_OUT && NEXT_IN)
            begin
                fetch_pending_ff <= 1'b1;
            end
            else if (reply_ok)
            begin
                fetch_pending_ff <= 1'b0;
            end
            if (READY_OUT && OPERAND_READ_IN && !NEXT_IN)
            begin
                operand_pending_ff <= 1'b1;
            end
            else if (reply_ok)
            begin
                operand_pending_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // unexpected sender
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            module_id_reg_ff <= 8'h00;
            mod_int_ff <= 1'b0;
        end
        else
        begin
            mod_int_ff <= 1'b0;
            if (to_me && !(bus.from_num == dest_ff && (fetch_pending_ff || operand_pending_ff)))
            begin
                module_id_reg_ff <= {bus.from_num, 1'b0, bus.mem_opcode, 2'h0};
                mod_int_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // bus drive
    // ----------------------------------------
    assign bus.cpu_drive = st_ff == cbt_pkg::CBT_SEL;
    assign bus.cpu_data = high_request_ff ? outgoing_data_reg_ff : outgoing_addr_reg_ff;
    assign bus.cpu_to = dest_ff;
    assign bus.cpu_from = MY_MODN;
    assign bus.cpu_mop = mem_opcode_ff;
    assign bus.cpu_rdy_pull = (st_ff == cbt_pkg::CBT_SEL && low_request_ff) ? (8'h01 << dest_ff) : 8'h00;
    assign bus.cpu_pri_pull = (st_ff == cbt_pkg::CBT_WAIT_PRIO || st_ff == cbt_pkg::CBT_SEL)
                              ? (8'h01 << MY_MODN) : 8'h00;

    assign CUR_INSTR_OUT = current_instr_reg_ff;
    assign PREFETCH_OUT = prefetch_instr_reg_ff;
    assign OPERAND_OUT = operand_reg_ff;
    assign SBUS_OUT = sbus_ff;
    assign SBUS_LOAD_OUT = sbus_load_ff;
    assign FETCH_PENDING_OUT = fetch_pending_ff;
    assign OPERAND_PENDING_OUT = operand_pending_ff;
    assign MODULE_ID_OUT = module_id_reg_ff;
    assign MODULE_INT_OUT = mod_int_ff;
endmodule

/* File: dv/cbt_bus_sva.sv */
// concurrent checks on the bus between processor and memory ends
`timescale 1ns/1ns
module cbt_bus_sva #(
    parameter logic [2:0] CPU_N = 3'h1,
    parameter logic [2:0] MEM_N = 3'h2
) (
    // clock and reset
    input  wire logic       REF_CLK_IN,
    input  wire logic       RST_IN,
    // shared lines
    input  wire logic       iop_req,
    input  wire logic [7:0] rdy_n_pull,
    input  wire logic [7:0] pri_n,
    // end drives
    input  wire logic       cpu_drive,
    input  wire logic [2:0] cpu_to,
    input  wire logic [2:0] cpu_from,
    input  wire logic [1:0] cpu_mop,
    input  wire logic [7:0] cpu_rdy_pull,
    input  wire logic       mem_drive,
    input  wire logic [2:0] mem_from,
    input  wire logic [2:0] mem_to,
    input  wire logic [7:0] mem_rdy_pull,
    input  wire logic [7:0] mem_pri_pull
);
    // modules numbered below the memory outrank it
    localparam logic [7:0] MHI = (8'h01 << MEM_N) - 8'h01;
    logic addr_go;
    logic rd_go;
    assign addr_go = cpu_drive && cpu_to == MEM_N && cpu_mop inside {cbt_pkg::MOP_READ, cbt_pkg::MOP_WRITE};
    assign rd_go = addr_go && cpu_mop == cbt_pkg::MOP_READ;

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    AST_SEL_ONE: assert property (cpu_drive |=> !cpu_drive) else $error("cpu drive longer than one cycle");
    AST_SEL_FROM: assert property (cpu_drive |-> cpu_from == CPU_N && cpu_to == MEM_N)
        else $error("cpu module numbers wrong");
    AST_SEL_IOP: assert property (cpu_drive |-> !$past(iop_req)) else $error("cpu drove over iop");
    AST_SEL_RDY: assert property (cpu_drive && cpu_mop != cbt_pkg::MOP_NOP |-> cpu_rdy_pull[cpu_to])
        else $error("destination ready not held");
    AST_LOW_RDY: assert property (addr_go |-> !$past(rdy_n_pull[cpu_to])) else $error("sent to busy module");
    AST_MEM_HOLD: assert property (addr_go |=> mem_rdy_pull[MEM_N] [*2]) else $error("memory ready not held");
    AST_MEM_REPLY: assert property (rd_go |-> ##3 mem_drive && mem_to == $past(cpu_from, 3))
        else $error("read reply late or misdirected");
    AST_MEM_SRC: assert property (mem_drive |-> mem_from == MEM_N) else $error("memory source wrong");
    AST_MEM_REQ_FIRST: assert property (mem_drive |-> $past(mem_pri_pull[MEM_N]))
        else $error("no request before drive");
    AST_MEM_PRIO: assert property (mem_drive |-> &(pri_n | ~MHI)) else $error("memory drove while blocked");
    AST_RST: assert property (disable iff (1'b0) RST_IN |=> !cpu_drive && !mem_drive && cpu_rdy_pull == 8'h00)
        else $error("bus not idle after reset");
endmodule

/* File: dv/central_bus_module_transfer_test.sv */
// self-checking bench: processor and memory ends joined on one bus
`timescale 1ns/1ns
module central_bus_module_transfer_test;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        next_s = 1'b0, rd_s = 1'b0, wr_s = 1'b0, dat_s = 1'b0;
    logic        stall = 1'b0, iop = 1'b0, f_drive = 1'b0;
    logic [15:0] p_in = 16'h0000, ubus = 16'h0000;
    logic [2:0]  dest = cbt_pkg::MEM_MODN_DEF;
    logic [1:0]  mem_opcode = cbt_pkg::MOP_READ;
    integer      seed = 3, err_count = 0, n_checks = 0, n, i;
    logic [33:0] exp_q [$];
    logic [15:0] model [0:255];
    logic [15:0] addrs [$];
    logic [15:0] a, d, pf_last = 16'h0000, op_exp, sbus, operand_reg, pf, cinstr, maddr, mwdata;
    logic        rdy, fp, opp, mwr, mbusy, mint, fp_d = 1'b0, op_d = 1'b0, stall_d = 1'b0, busy_seen, sld, mint_a;
    logic [7:0]  mid;

    always #5 ref_clk = ~ref_clk;

    // ----------------------------------------
    // main pair and a processor facing a rogue sender
    // ----------------------------------------
    cbt_bus_if bus_a ();
    cbt_bus_if bus_f ();
    assign bus_a.iop_req = iop;
    assign bus_f.iop_req = 1'b0;
    assign bus_f.mem_data = 16'h5A5A;
    assign bus_f.mem_to = cbt_pkg::CPU_MODN_DEF;
    assign bus_f.mem_from = 3'h5;
    assign bus_f.mem_mop = cbt_pkg::MOP_READ;
    assign bus_f.mem_drive = f_drive;
    assign bus_f.mem_rdy_pull = 8'h00;
    assign bus_f.mem_pri_pull = 8'h00;

    cbt_cpu_end u_cbt_cpu_end (.REF_CLK_IN(ref_clk), .RST_IN(rst), .bus(bus_a), .NEXT_IN(next_s),
        .OPERAND_READ_IN(rd_s), .OPERAND_WRITE_IN(wr_s), .DATA_IN(dat_s), .P_IN(p_in), .UBUS_IN(ubus),
        .DEST_IN(dest), .MOP_IN(mem_opcode), .STALLED_IN(stall), .READY_OUT(rdy), .CUR_INSTR_OUT(cinstr),
        .PREFETCH_OUT(pf), .OPERAND_OUT(operand_reg), .SBUS_OUT(sbus), .SBUS_LOAD_OUT(sld), .FETCH_PENDING_OUT(fp),
        .OPERAND_PENDING_OUT(opp), .MODULE_ID_OUT(), .MODULE_INT_OUT(mint_a));
    cbt_mem_end u_cbt_mem_end (.REF_CLK_IN(ref_clk), .RST_IN(rst), .bus(bus_a), .MEM_WR_OUT(mwr),
        .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwdata), .MEM_BUSY_OUT(mbusy));
    cbt_cpu_end u_cbt_cpu_end_f (.REF_CLK_IN(ref_clk), .RST_IN(rst), .bus(bus_f), .NEXT_IN(1'b0),
        .OPERAND_READ_IN(1'b0), .OPERAND_WRITE_IN(1'b0), .DATA_IN(1'b0), .P_IN(p_in), .UBUS_IN(ubus),
        .DEST_IN(dest), .MOP_IN(mem_opcode), .STALLED_IN(1'b0), .READY_OUT(), .CUR_INSTR_OUT(), .PREFETCH_OUT(),
        .OPERAND_OUT(), .SBUS_OUT(), .SBUS_LOAD_OUT(), .FETCH_PENDING_OUT(), .OPERAND_PENDING_OUT(),
        .MODULE_ID_OUT(mid), .MODULE_INT_OUT(mint));
    cbt_bus_sva #(.CPU_N(cbt_pkg::CPU_MODN_DEF), .MEM_N(cbt_pkg::MEM_MODN_DEF)) u_sva (.REF_CLK_IN(ref_clk),
        .RST_IN(rst), .iop_req(bus_a.iop_req), .rdy_n_pull(bus_a.rdy_n_pull), .pri_n(bus_a.pri_n),
        .cpu_drive(bus_a.cpu_drive), .cpu_to(bus_a.cpu_to), .cpu_from(bus_a.cpu_from), .cpu_mop(bus_a.cpu_mop),
        .cpu_rdy_pull(bus_a.cpu_rdy_pull), .mem_drive(bus_a.mem_drive), .mem_from(bus_a.mem_from),
        .mem_to(bus_a.mem_to), .mem_rdy_pull(bus_a.mem_rdy_pull), .mem_pri_pull(bus_a.mem_pri_pull));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // an empty queue yields a kind never noted, so a stray result fails
    task automatic take(input logic [33:0] seen);
        check(seen, (exp_q.size() != 0) ? exp_q.pop_front() : 34'h300000000);
    endtask

    // orders are raised only once the ready level is settled high
    task automatic order(input int k, input logic [15:0] v, input logic [1:0] m, input logic st);
        int w;
        w = 0;
        @(negedge ref_clk);
        while (rdy !== 1'b1 && w < 300)
        begin
            @(negedge ref_clk);
            w = w + 1;
        end
        check(w < 300, 1'b1);
        @(posedge ref_clk);
        p_in <= v;
        ubus <= v;
        mem_opcode <= m;
        stall <= st;
        next_s <= (k == 0);
        rd_s <= (k == 1);
        wr_s <= (k == 2);
        dat_s <= (k == 3);
        @(posedge ref_clk);
        {next_s, rd_s, wr_s, dat_s} <= 4'h0;
    endtask

    task automatic drain();
        int w;
        w = 0;
        while (exp_q.size() != 0 && w < 300)
        begin
            @(negedge ref_clk);
            w = w + 1;
        end
        check(exp_q.size(), 0);
    endtask

    task automatic rd(input logic [15:0] ad, input logic st);
        op_exp = model[ad[7:0]];
        stall_d = st;
        exp_q.push_back({2'h1, 16'h0000, op_exp});
        order(1, ad, cbt_pkg::MOP_READ, st);
        drain();
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(negedge ref_clk)
    begin
        fp_d <= fp;
        op_d <= opp;
        if (fp_d && !fp)
            take({2'h0, 16'h0000, pf});
        if (op_d && !opp)
            take({2'h1, 16'h0000, operand_reg});
        if (op_d && !opp && stall_d)
            check(sbus, op_exp);
        if (op_d && !opp)
            check(sld, stall_d);
        // the main processor only ever hears expected replies
        if (mint_a !== 1'b0)
            check(mint_a, 1'b0);
        if (mwr === 1'b1)
            take({2'h2, maddr, mwdata});
        if (mbusy === 1'b1)
            busy_seen = 1'b1;
    end

    initial
    begin
        #50000;
        err_count = err_count + 1;
        summarize();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        f_drive <= 1'b1;
        @(posedge ref_clk);
        f_drive <= 1'b0;
        n = 0;
        while (mint !== 1'b1 && n < 8)
        begin
            @(negedge ref_clk);
            n = n + 1;
        end
        check({n < 8, mid[7:5], mid[3:2]}, {1'b1, 3'h5, cbt_pkg::MOP_READ});
        for (i = 0; i < 6; i = i + 1)
        begin
            a = 16'($random(seed));
            d = 16'($random(seed));
            addrs.push_back(a);
            model[a[7:0]] = d;
            exp_q.push_back({2'h2, a, d});
            order(2, a, cbt_pkg::MOP_WRITE, 1'b0);
            order(3, d, cbt_pkg::MOP_NOP, 1'b0);
            drain();
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            @(posedge ref_clk);
            iop <= (i == 2);
            exp_q.push_back({2'h0, 16'h0000, model[addrs[i][7:0]]});
            order(0, addrs[i], cbt_pkg::MOP_READ, 1'b0);
            @(negedge ref_clk);
            @(negedge ref_clk);
            check(cinstr, pf_last);
            pf_last = model[addrs[i][7:0]];
            if (i == 2)
            begin
                repeat (6) @(negedge ref_clk);
                check(bus_a.cpu_drive, 1'b0);
                @(posedge ref_clk);
                iop <= 1'b0;
            end
            drain();
        end
        for (i = 0; i < 6; i = i + 1)
            rd(addrs[i], i[0]);
        for (i = 0; i < 2; i = i + 1)
        begin
            busy_seen = 1'b0;
            order(1, addrs[0], i ? cbt_pkg::MOP_RD_ONES : cbt_pkg::MOP_NOP, 1'b0);
            repeat (10) @(negedge ref_clk);
            check(busy_seen, 1'b0);
            rd(addrs[i + 2], 1'b1);
        end
        summarize();
    end
endmodule
